// *** rtl/twi_st_map.svh ***
// Register map, status codes, field positions and timing of the slave transmitter
`ifndef TWI_ST_MAP_SVH
`define TWI_ST_MAP_SVH
// Register indexes on the plain register port
`define REG_CTRL 3'h0
`define REG_ADDR 3'h1
`define REG_STAT 3'h2
`define REG_DATA 3'h3
`define REG_IRQ 3'h4
`define REG_MASK 3'h5
// Control register bit positions
`define CB_FLAG 7
`define CB_ACK 6
`define CB_STA 5
`define CB_STO 4
`define CB_EN 2
// Interrupt status bit positions
`define IRQ_DONE 0
`define IRQ_BERR 1
// Status codes, full byte with prescaler bits zero
`define CODE_SLA_R 8'hA8
`define CODE_ARB_SLA_R 8'hB0
`define CODE_TX_ACK 8'hB8
`define CODE_TX_NACK 8'hC0
`define CODE_LAST_ACK 8'hC8
`define CODE_IDLE 8'hF8
`define CODE_BUS_ERR 8'h00
`define CODE_START 8'h08
`define CODE_RSTART 8'h10
// Address constants
`define GEN_CALL_ADDR 7'h00
// Bit counter marks
`define LAST_BIT 4'h7
`define ACK_BIT 4'h8
// Reset values
`define LINE_IDLE 2'h3
`define ADDR_RESET 8'h00
// Timing of own bus conditions
`define CLK_MHZ 10
`define T_QUARTER_NS 200
`define QTR_CYC ((`T_QUARTER_NS * `CLK_MHZ + 999) / 1000)
`endif

// *** rtl/twi_st_pkg.sv ***
// Types shared by the slave transmitter block
package twi_st_pkg;
   typedef enum logic [3:0] {
      S_IDLE, S_ADDR, S_ADDR_ACK, S_TX, S_TX_ACK, S_WAIT,
      M_START, M_OWN, M_RSTART, M_STOP
   } phase_e;
   typedef logic [4:0] code_t;
endpackage

// *** rtl/bus_line_sync.sv ***
// Two-flop synchroniser for the clock and data bus lines
`timescale 1ns/1ns
`include "twi_st_map.svh"
module bus_line_sync (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [1:0] lineIn,
   output logic [1:0] lineOut
);
   logic [1:0] meta_q;
   logic [1:0] sync_q;

   // First stage feeds only the second
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         meta_q <= `LINE_IDLE;
         sync_q <= `LINE_IDLE;
      end else begin
         meta_q <= lineIn;
         sync_q <= meta_q;
      end
   end

   assign lineOut = sync_q;
endmodule

// *** rtl/twi_slave_transmit_status.sv ***
// Two-wire slave transmitter with status, bus error and repeated start handling
`timescale 1ns/1ns
`include "twi_st_map.svh"
// Notes on behaviour
// - Own address with read acked gives A8
// - Lost arbitration then addressed for read: B0
// - Byte sent, ack received gives B8
// - Byte sent, not-ack received gives C0
// - Last byte acked anyway gives C8
// - Ack enable picks last byte or more
// - After C0/C8 go unaddressed; ack off ignores
// - Ack on: own address, general call if enabled
// - Start request: start once bus is free
// - Flag clear means status reads F8
// - Misplaced start or stop sets bus error 00
// - Recovery: unaddressed, stop cleared, lines released
// - Master keeps bus across repeated start
// - Code in bits 7:3, prescaler low
// - Flag set holds clock line low while enabled
// - After last byte data line stays released
module twi_slave_transmit_status
   import twi_st_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [2:0] addr,
   input wire logic [7:0] wrData,
   input wire logic wrStb,
   input wire logic rdStb,
   output logic [7:0] rdData,
   output logic irq,
   input wire logic sclIn,
   output logic sclOut,
   output logic sclOe,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe
);
   phase_e st_q, st_d;
   logic flag_q, flag_d, ackEn_q, ackEn_d, staReq_q, staReq_d;
   logic stoReq_q, stoReq_d, en_q, en_d, gce_q, gce_d;
   logic [6:0] ownAddr_q, ownAddr_d;
   logic [1:0] presc_q, presc_d, irqSt_q, irqSt_d, mask_q, mask_d;
   logic [7:0] dat_q, dat_d, code_q, code_d, rdData_q, rdData_d;
   logic [3:0] bitCnt_q, bitCnt_d, tmr_q, tmr_d;
   logic [1:0] ph_q, ph_d;
   logic last_q, last_d, ackSeen_q, ackSeen_d, lostArb_q, lostArb_d;
   logic busy_q, busy_d, sdaDrv_q, sdaDrv_d, mScl_q, mScl_d;
   logic sclOe_q, sclOe_d, irq_q, irq_d;
   logic flagSet, berrSet;
   logic [1:0] lineS;
   logic sclS, sdaS, sclP, sdaP;
   logic sclRise, sclFall, startDet, stopDet, qTick;
   logic wrCtrl, flagClr, clearing;

   // Status field: code while flag set, idle code otherwise
   function automatic code_t codeField(input logic flag, input logic [7:0] code);
      logic [7:0] full;
      full = flag ? code : `CODE_IDLE;
      return full[7:3];
   endfunction

   bus_line_sync lineSync (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .lineIn({sclIn, sdaIn}),
      .lineOut(lineS)
   );

   // Bus condition detection on synchronised lines
   assign sclS = lineS[1];
   assign sdaS = lineS[0];
   assign sclRise = sclS & ~sclP;
   assign sclFall = ~sclS & sclP;
   assign startDet = sclS & sclP & sdaP & ~sdaS;
   assign stopDet = sclS & sclP & ~sdaP & sdaS;
   assign qTick = tmr_q == 4'(`QTR_CYC - 1);
   assign wrCtrl = wrStb && (addr == `REG_CTRL);
   assign flagClr = wrCtrl && wrData[`CB_FLAG];
   assign clearing = flagClr && flag_q;

   // Register writes, bus state machine and own conditions
   always_comb begin
      st_d = st_q;
      ackEn_d = ackEn_q;
      staReq_d = staReq_q;
      stoReq_d = stoReq_q;
      en_d = en_q;
      gce_d = gce_q;
      ownAddr_d = ownAddr_q;
      presc_d = presc_q;
      mask_d = mask_q;
      dat_d = dat_q;
      code_d = code_q;
      bitCnt_d = bitCnt_q;
      ph_d = ph_q;
      last_d = last_q;
      ackSeen_d = ackSeen_q;
      lostArb_d = lostArb_q;
      busy_d = busy_q;
      sdaDrv_d = sdaDrv_q;
      mScl_d = mScl_q;
      tmr_d = (st_q >= M_START && !qTick) ? tmr_q + 4'h1 : 4'h0;
      flagSet = 1'b0;
      berrSet = 1'b0;
      if (wrStb) begin
         case (addr)
            `REG_CTRL: begin
               ackEn_d = wrData[`CB_ACK];
               staReq_d = wrData[`CB_STA];
               stoReq_d = wrData[`CB_STO];
               en_d = wrData[`CB_EN];
            end
            `REG_ADDR: begin
               ownAddr_d = wrData[7:1];
               gce_d = wrData[0];
            end
            `REG_STAT: presc_d = wrData[1:0];
            `REG_DATA: if (flag_q) dat_d = wrData;
            `REG_MASK: mask_d = wrData[1:0];
            default: ;
         endcase
      end
      if (startDet) busy_d = 1'b1;
      if (stopDet) busy_d = 1'b0;
      case (st_q)
         S_IDLE: begin
            sdaDrv_d = 1'b0;
            if (startDet) begin
               if (staReq_q) lostArb_d = 1'b1;
               st_d = S_ADDR;
               bitCnt_d = 4'h0;
            end else if (staReq_d && !busy_q && !flag_q) begin
               st_d = M_START;
               ph_d = 2'h0;
            end
         end
         S_ADDR: begin
            if ((startDet || stopDet) && bitCnt_q != 4'h0) begin
               berrSet = 1'b1;
            end else if (stopDet) begin
               st_d = S_IDLE;
            end else if (startDet) begin
               bitCnt_d = 4'h0;
            end else if (sclRise) begin
               dat_d = {dat_q[6:0], sdaS};
               bitCnt_d = bitCnt_q + 4'h1;
            end else if (sclFall && bitCnt_q == `ACK_BIT) begin
               // Own address or enabled general call
               if (ackEn_q && dat_q[0] && (dat_q[7:1] == ownAddr_q
                   || (gce_q && dat_q[7:1] == `GEN_CALL_ADDR))) begin
                  st_d = S_ADDR_ACK;
                  sdaDrv_d = 1'b1;
               end else begin
                  // Not addressed, wait for next start
                  st_d = S_IDLE;
                  lostArb_d = 1'b0;
               end
            end
         end
         S_ADDR_ACK: begin
            if (startDet || stopDet) begin
               berrSet = 1'b1;
            end else if (sclFall) begin
               flagSet = 1'b1;
               code_d = lostArb_q ? `CODE_ARB_SLA_R : `CODE_SLA_R;
               lostArb_d = 1'b0;
               sdaDrv_d = 1'b0;
               st_d = S_WAIT;
            end
         end
         S_TX: begin
            if ((startDet || stopDet) && bitCnt_q != 4'h0) begin
               berrSet = 1'b1;
            end else if (sclFall) begin
               // Next bit driven while clock low
               bitCnt_d = bitCnt_q + 4'h1;
               if (bitCnt_q == `LAST_BIT) begin
                  sdaDrv_d = 1'b0;
                  st_d = S_TX_ACK;
               end else begin
                  dat_d = {dat_q[6:0], 1'b1};
                  sdaDrv_d = ~dat_q[6];
               end
            end
         end
         S_TX_ACK: begin
            if (startDet || stopDet) begin
               berrSet = 1'b1;
            end else if (sclRise) begin
               ackSeen_d = ~sdaS;
               bitCnt_d = `ACK_BIT;
            end else if (sclFall && bitCnt_q == `ACK_BIT) begin
               flagSet = 1'b1;
               code_d = !ackSeen_q ? `CODE_TX_NACK
                      : (last_q ? `CODE_LAST_ACK : `CODE_TX_ACK);
               st_d = S_WAIT;
            end
         end
         S_WAIT: begin
            if (code_q == `CODE_BUS_ERR) begin
               if (flagClr && stoReq_d) begin
                  stoReq_d = 1'b0;
                  busy_d = 1'b0;
                  st_d = S_IDLE;
               end
            end else if (clearing) begin
               if (code_q == `CODE_TX_NACK || code_q == `CODE_LAST_ACK) begin
                  st_d = S_IDLE;
               end else begin
                  last_d = ~ackEn_d;
                  bitCnt_d = 4'h0;
                  sdaDrv_d = ~dat_q[7];
                  st_d = S_TX;
               end
            end
         end
         M_START: begin
            if (ph_q == 2'h0 && startDet) begin
               lostArb_d = 1'b1;
               bitCnt_d = 4'h0;
               st_d = S_ADDR;
            end else if (qTick && ph_q == 2'h0) begin
               sdaDrv_d = 1'b1;
               ph_d = 2'h1;
            end else if (qTick) begin
               mScl_d = 1'b1;
               flagSet = 1'b1;
               code_d = `CODE_START;
               st_d = M_OWN;
            end
         end
         M_OWN: begin
            if (clearing && stoReq_d) begin
               st_d = M_STOP;
               ph_d = 2'h0;
            end else if (clearing && staReq_d) begin
               st_d = M_RSTART;
               ph_d = 2'h0;
            end
         end
         M_RSTART: begin
            if (qTick) begin
               case (ph_q)
                  2'h0: sdaDrv_d = 1'b0;
                  2'h1: mScl_d = 1'b0;
                  2'h2: sdaDrv_d = sclS;
                  default: begin
                     mScl_d = 1'b1;
                     flagSet = 1'b1;
                     code_d = `CODE_RSTART;
                     st_d = M_OWN;
                  end
               endcase
               if (ph_q != 2'h2 || sclS) ph_d = ph_q + 2'h1;
            end
         end
         M_STOP: begin
            if (qTick) begin
               case (ph_q)
                  2'h0: sdaDrv_d = 1'b1;
                  2'h1: mScl_d = 1'b0;
                  default: begin
                     if (sclS) begin
                        sdaDrv_d = 1'b0;
                        stoReq_d = 1'b0;
                        st_d = S_IDLE;
                     end
                  end
               endcase
               if (ph_q == 2'h0 || ph_q == 2'h1) ph_d = ph_q + 2'h1;
            end
         end
         default: st_d = S_IDLE;
      endcase
      if (berrSet) begin
         // Illegal condition reported as bus error
         flagSet = 1'b1;
         code_d = `CODE_BUS_ERR;
         sdaDrv_d = 1'b0;
         st_d = S_WAIT;
      end
      if (!en_d) begin
         st_d = S_IDLE;
         sdaDrv_d = 1'b0;
         mScl_d = 1'b0;
      end
      // Hardware set wins over software clear
      flag_d = flagSet | (flag_q & ~flagClr);
      irqSt_d = {berrSet, flagSet} | (irqSt_q & ~((wrStb && addr == `REG_IRQ)
                ? wrData[1:0] : 2'h0));
      irq_d = |(irqSt_d & mask_d);
      // Clock held low while flag set and enabled
      sclOe_d = (flag_d & en_d) | mScl_d;
      rdData_d = 8'h00;
      if (rdStb) begin
         case (addr)
            `REG_CTRL: rdData_d = {flag_q, ackEn_q, staReq_q, stoReq_q, 1'b0, en_q, 2'h0};
            `REG_ADDR: rdData_d = {ownAddr_q, gce_q};
            `REG_STAT: rdData_d = {codeField(flag_q, code_q), 1'b0, presc_q};
            `REG_DATA: rdData_d = dat_q;
            `REG_IRQ: rdData_d = {6'h00, irqSt_q};
            `REG_MASK: rdData_d = {6'h00, mask_q};
            default: rdData_d = 8'h00;
         endcase
      end
   end

   // State registers
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         st_q <= S_IDLE;
         flag_q <= 1'b0;
         ackEn_q <= 1'b0;
         staReq_q <= 1'b0;
         stoReq_q <= 1'b0;
         en_q <= 1'b0;
         gce_q <= 1'b0;
         ownAddr_q <= 7'(`ADDR_RESET);
         presc_q <= 2'h0;
         irqSt_q <= 2'h0;
         mask_q <= 2'h0;
         dat_q <= 8'h00;
         code_q <= `CODE_IDLE;
         rdData_q <= 8'h00;
         bitCnt_q <= 4'h0;
         tmr_q <= 4'h0;
         ph_q <= 2'h0;
         last_q <= 1'b0;
         ackSeen_q <= 1'b0;
         lostArb_q <= 1'b0;
         busy_q <= 1'b0;
         sdaDrv_q <= 1'b0;
         mScl_q <= 1'b0;
         sclOe_q <= 1'b0;
         irq_q <= 1'b0;
         sclP <= 1'b1;
         sdaP <= 1'b1;
      end else begin
         st_q <= st_d;
         flag_q <= flag_d;
         ackEn_q <= ackEn_d;
         staReq_q <= staReq_d;
         stoReq_q <= stoReq_d;
         en_q <= en_d;
         gce_q <= gce_d;
         ownAddr_q <= ownAddr_d;
         presc_q <= presc_d;
         irqSt_q <= irqSt_d;
         mask_q <= mask_d;
         dat_q <= dat_d;
         code_q <= code_d;
         rdData_q <= rdData_d;
         bitCnt_q <= bitCnt_d;
         tmr_q <= tmr_d;
         ph_q <= ph_d;
         last_q <= last_d;
         ackSeen_q <= ackSeen_d;
         lostArb_q <= lostArb_d;
         busy_q <= busy_d;
         sdaDrv_q <= sdaDrv_d;
         mScl_q <= mScl_d;
         sclOe_q <= sclOe_d;
         irq_q <= irq_d;
         sclP <= sclS;
         sdaP <= sdaS;
      end
   end

   // Open-drain pins only ever pull low
   assign sclOut = 1'b0;
   assign sdaOut = 1'b0;
   assign sclOe = sclOe_q;
   assign sdaOe = sdaDrv_q;
   assign rdData = rdData_q;
   assign irq = irq_q;

   // Checks on the block's own behaviour
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   a_status_idle_read: assert property (
      !flag_q |-> codeField(flag_q, code_q) == 5'h1F)
      else $error("status field not idle while flag clear");
   a_addr_read_code: assert property (
      st_q == S_ADDR_ACK && sclFall && !lostArb_q && !startDet && !stopDet && en_d
      |=> flag_q && code_q == `CODE_SLA_R && sclOe)
      else $error("address read code missing");
   a_arb_lost_code: assert property (
      st_q == S_ADDR_ACK && sclFall && lostArb_q && !startDet && !stopDet && en_d
      |=> code_q == `CODE_ARB_SLA_R)
      else $error("arbitration lost code missing");
   a_byte_acked_code: assert property (
      st_q == S_TX_ACK && sclFall && bitCnt_q == `ACK_BIT && ackSeen_q && !last_q
      && !startDet && !stopDet && en_d |=> flag_q && code_q == `CODE_TX_ACK)
      else $error("byte ack code missing");
   a_byte_nack_code: assert property (
      st_q == S_TX_ACK && sclFall && bitCnt_q == `ACK_BIT && !ackSeen_q
      && !startDet && !stopDet && en_d |=> code_q == `CODE_TX_NACK)
      else $error("byte nack code missing");
   a_last_acked_code: assert property (
      st_q == S_TX_ACK && sclFall && bitCnt_q == `ACK_BIT && ackSeen_q && last_q
      && !startDet && !stopDet && en_d |=> code_q == `CODE_LAST_ACK)
      else $error("last byte ack code missing");
   a_clock_stretch: assert property (
      flag_q && en_q |-> sclOe ##1 (sclOe || !flag_q || !en_q))
      else $error("clock not held while flag set");
   a_bus_err_code: assert property (
      st_q == S_TX && bitCnt_q != 4'h0 && (startDet || stopDet) && en_d
      |=> flag_q && code_q == `CODE_BUS_ERR && !sdaOe)
      else $error("bus error not reported");
   a_err_recovery: assert property (
      st_q == S_WAIT && code_q == `CODE_BUS_ERR && flagClr && wrData[`CB_STO]
      && wrData[`CB_EN] |=> st_q == S_IDLE && !stoReq_q && !sdaOe && !sclOe
      && ackEn_q == $past(wrData[`CB_ACK]))
      else $error("bus error recovery wrong");
   a_leave_done_state: assert property (
      st_q == S_WAIT && clearing && wrData[`CB_EN]
      && (code_q == `CODE_TX_NACK || code_q == `CODE_LAST_ACK)
      |=> st_q == S_IDLE && !sdaOe)
      else $error("did not go unaddressed");
   a_first_bit_msb: assert property (
      st_q == S_WAIT && clearing && wrData[`CB_EN] && code_q == `CODE_SLA_R
      |=> st_q == S_TX && sdaOe == !$past(dat_q[7]) && !sclS)
      else $error("first bit not msb");
endmodule

// *** sim/twi_master_model.sv ***
// Behavioural two-wire bus master receiver with open-drain pulls
`timescale 1ns/1ns
module twi_master_model (
   input wire logic scl,
   input wire logic sda,
   output logic sclOe,
   output logic sdaOe
);
   localparam int QTR = 200;
   // Lines released at start
   initial begin
      sclOe = 1'b0;
      sdaOe = 1'b0;
   end
   // Release clock, wait out any stretch, then one quarter high
   task automatic rise();
      int n;
      n = 0;
      sclOe = 1'b0;
      while (scl !== 1'b1 && n < 5000) begin
         #100;
         n++;
      end
      #QTR;
   endtask
   // Start or repeated start from any line state
   task automatic start();
      sdaOe = 1'b0;
      #QTR;
      rise();
      sdaOe = 1'b1;
      #QTR;
      sclOe = 1'b1;
      #QTR;
   endtask
   // Stop, data rising while clock high
   task automatic stop();
      sdaOe = 1'b1;
      #QTR;
      rise();
      sdaOe = 1'b0;
      #QTR;
   endtask
   // MSB first bits
   // Data changes only while clock low; ack slot only for a full byte
   task automatic send(input logic [7:0] b, input int n, output logic ack);
      ack = 1'b0;
      for (int i = 7; i > 7 - n; i--) begin
         sdaOe = !b[i];
         #QTR;
         rise();
         #QTR;
         sclOe = 1'b1;
         #QTR;
      end
      if (n == 8) begin
         sdaOe = 1'b0;
         #QTR;
         rise();
         ack = (sda === 1'b0);
         #QTR;
         sclOe = 1'b1;
         #QTR;
      end
   endtask
   // Sample while high
   // Reads one byte and answers with ack or not-ack on the ninth clock
   task automatic recv(input logic ackIt, output logic [7:0] b);
      sdaOe = 1'b0;
      // Full half period low so the slave's late data change settles first
      for (int i = 7; i >= 0; i--) begin
         #QTR;
         rise();
         b[i] = sda;
         #QTR;
         sclOe = 1'b1;
         #QTR;
      end
      sdaOe = ackIt;
      #QTR;
      rise();
      #QTR;
      sclOe = 1'b1;
      #QTR;
      sdaOe = 1'b0;
   endtask
endmodule

// *** sim/tb.sv ***
// Self-checking bench for the two-wire slave transmitter
`timescale 1ns/1ns
`include "twi_st_map.svh"
module tb;
   localparam logic [6:0] ownSlaveAddress = 7'h2A;
   logic ref_clk;
   logic resetn;
   logic [2:0] addr;
   logic [7:0] wrData;
   logic wrStb;
   logic rdStb;
   logic [7:0] rdData;
   logic irq;
   logic sclOe;
   logic sdaOe;
   logic mScl;
   logic mSda;
   logic sclO;
   logic sdaO;
   wire scl;
   wire sda;
   int miscompares = 0;
   int checks = 0;
   integer seed = 32'h5D3F;
   logic [7:0] txQ[$];
   // Open-drain wires, high when nobody pulls
   assign scl = !(sclOe | mScl);
   assign sda = !(sdaOe | mSda);
   twi_slave_transmit_status uut (.ref_clk(ref_clk), .resetn(resetn), .addr(addr),
      .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .irq(irq),
      .sclIn(scl), .sclOut(sclO), .sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaO), .sdaOe(sdaOe));
   twi_master_model master (.scl(scl), .sda(sda), .sclOe(mScl), .sdaOe(mSda));
   // Clock at 10 MHz
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   // Register bus cycles, one strobe cycle each
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      wrData <= d;
      wrStb <= 1'b1;
      @(posedge ref_clk);
      wrStb <= 1'b0;
   endtask
   task automatic rdChk(input logic [2:0] a, input logic [7:0] exp, input string what);
      @(posedge ref_clk);
      addr <= a;
      rdStb <= 1'b1;
      @(posedge ref_clk);
      rdStb <= 1'b0;
      #1 chk(rdData, exp, what);
   endtask
   // Control write that clears the flag with enable set
   function automatic logic [7:0] clr(input logic a, input logic s, input logic p);
      return {1'b1, a, s, p, 4'h4};
   endfunction
   // Reference model of the code after a sent byte
   function automatic logic [7:0] expCode(input logic en, input logic acked);
      if (!acked) return `CODE_TX_NACK;
      return en ? `CODE_TX_ACK : `CODE_LAST_ACK;
   endfunction
   // Wait for the flag interrupt, check code and stretch, clear sticky bits
   task automatic serve(input logic [7:0] code, input string what);
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 300) begin
         @(posedge ref_clk);
         n++;
      end
      rdChk(`REG_STAT, code, what);
      chk({7'h00, sclOe}, 8'h01, "clock stretch");
      wr(`REG_IRQ, 8'h03);
      repeat (2) @(posedge ref_clk);
      #1 chk({7'h00, irq}, 8'h00, "irq cleared");
   endtask
   task automatic addrRead(input logic [6:0] a, input logic expAck);
      logic ack;
      master.start();
      master.send({a, 1'b1}, 8, ack);
      chk({7'h00, ack}, {7'h00, expAck}, "address ack");
   endtask
   // Load a random byte, let the master read it, compare with the queue
   task automatic xfer(input logic en, input logic ackIt);
      logic [7:0] b;
      logic [7:0] exp;
      b = $random(seed);
      txQ.push_back(b);
      wr(`REG_DATA, b);
      wr(`REG_CTRL, clr(en, 1'b0, 1'b0));
      master.recv(ackIt, b);
      exp = txQ.pop_front();
      chk(b, exp, "byte on line");
      serve(expCode(en, ackIt), "after byte");
   endtask
   // Watchdog
   initial begin
      #2000000;
      miscompares++;
      $display("Watchdog expired");
      report_and_stop();
   end
   // Main sequence
   initial begin
      logic [7:0] v;
      resetn = 1'b0;
      addr = 3'h0;
      wrData = 8'h00;
      wrStb = 1'b0;
      rdStb = 1'b0;
      repeat (20) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rdChk(`REG_STAT, `CODE_IDLE, "idle status");
      rdChk(`REG_ADDR, `ADDR_RESET, "address reset");
      rdChk(`REG_MASK, 8'h00, "mask reset");
      wr(3'h7, 8'hFF);
      rdChk(3'h7, 8'h00, "unmapped");
      wr(`REG_STAT, 8'h03);
      rdChk(`REG_STAT, `CODE_IDLE | 8'h03, "prescaler");
      wr(`REG_STAT, 8'h00);
      wr(`REG_ADDR, {ownSlaveAddress, 1'b1});
      wr(`REG_MASK, 8'h03);
      wr(`REG_CTRL, 8'h44);
      $display("Test registers done");
      addrRead(ownSlaveAddress, 1'b1);
      serve(`CODE_SLA_R, "own read");
      xfer(1'b1, 1'b1);
      xfer(1'b0, 1'b1);
      wr(`REG_CTRL, clr(1'b1, 1'b0, 1'b0));
      master.recv(1'b0, v);
      chk(v, 8'hFF, "released data");
      master.stop();
      $display("Test read transfer done");
      addrRead(ownSlaveAddress, 1'b1);
      serve(`CODE_SLA_R, "own read");
      xfer(1'b1, 1'b0);
      wr(`REG_CTRL, clr(1'b0, 1'b0, 1'b0));
      master.stop();
      addrRead(ownSlaveAddress, 1'b0);
      master.stop();
      wr(`REG_CTRL, 8'h44);
      addrRead(7'h00, 1'b1);
      serve(`CODE_SLA_R, "general call");
      xfer(1'b0, 1'b0);
      wr(`REG_CTRL, clr(1'b1, 1'b0, 1'b0));
      master.stop();
      wr(`REG_ADDR, {ownSlaveAddress, 1'b0});
      addrRead(7'h00, 1'b0);
      master.stop();
      $display("Test addressing done");
      wr(`REG_MASK, 8'h00);
      master.start();
      master.send({ownSlaveAddress, 1'b1}, 3, v[0]);
      master.stop();
      repeat (10) @(posedge ref_clk);
      #1 chk({7'h00, irq}, 8'h00, "masked irq");
      rdChk(`REG_IRQ, 8'h03, "error sticky");
      wr(`REG_MASK, 8'h03);
      serve(`CODE_BUS_ERR, "bus error");
      wr(`REG_CTRL, clr(1'b1, 1'b0, 1'b1));
      rdChk(`REG_CTRL, 8'h44, "stop cleared");
      chk({6'h00, sclOe, sdaOe}, 8'h00, "lines released");
      chk({6'h00, sclO, sdaO}, 8'h00, "open drain levels");
      rdChk(`REG_STAT, `CODE_IDLE, "idle after error");
      $display("Test bus error done");
      addrRead(7'h55, 1'b0);
      wr(`REG_CTRL, 8'h64);
      addrRead(ownSlaveAddress, 1'b1);
      serve(`CODE_ARB_SLA_R, "lost arbitration");
      xfer(1'b0, 1'b0);
      wr(`REG_CTRL, clr(1'b1, 1'b1, 1'b0));
      master.stop();
      serve(`CODE_START, "own start");
      wr(`REG_CTRL, clr(1'b1, 1'b1, 1'b0));
      serve(`CODE_RSTART, "repeated start");
      wr(`REG_CTRL, clr(1'b1, 1'b0, 1'b1));
      repeat (40) @(posedge ref_clk);
      rdChk(`REG_CTRL, 8'h44, "stop done");
      chk({6'h00, sclOe, sdaOe}, 8'h00, "bus freed");
      $display("Test master codes done");
      report_and_stop();
   end
endmodule
